//--- rtl/relay_out_params.svh
// Constants for the relay output matrix and indication block
`ifndef RELAY_OUT_PARAMS_SVH
`define RELAY_OUT_PARAMS_SVH
`define NUM_STAGES 4
`define NUM_OUTS 4
`define SGB_BIT_IND 5
`define SGB_BIT_LATCH 6
`define SGB_BIT_REG 7
`define CODE_NONE 4'h0
`define CODE_U1_START 4'h1
`define CODE_LO_START 4'h2
`define CODE_HI_START 4'h3
`define CODE_U2_START 4'h4
`define CODE_TR_START 4'h6
`define CODE_LO_TRIP 4'h7
`define CODE_HI_TRIP 4'h8
`define CODE_TR_TRIP 4'h9
`define FAULT_DIGIT 4'h1
`endif

//--- rtl/relay_out_pkg.sv
// Types for the relay output matrix and indication block
package relay_out_pkg;
  typedef logic [3:0] code_t;
  typedef enum logic [2:0] {
    CLR_NONE = 3'b001,
    CLR_IND = 3'b010,
    CLR_DEEP = 3'b100
  } clr_kind_t;
endpackage

//--- rtl/pin_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  if (WIDTH < 1) begin : gBadWidth
    $error("pin_sync width must be positive");
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule
`default_nettype wire

//--- rtl/relay_output_matrix_indication.sv
// Output matrix, latching, reset sources and indication logic
`timescale 1ns/1ps
`default_nettype none
`include "relay_out_params.svh"
module relay_output_matrix_indication #(
  parameter int NSTG = `NUM_STAGES,
  parameter int NOUT = `NUM_OUTS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [NSTG-1:0] stageStart,
  input wire logic [NSTG-1:0] stageTrip,
  input wire logic u1Start,
  input wire logic intermittentOp,
  input wire logic [NSTG*NOUT-1:0] startMatrix,
  input wire logic [NSTG*NOUT-1:0] tripMatrix,
  input wire logic [NOUT-1:0] latchSel,
  input wire logic [NSTG-1:0] reclStartSel,
  input wire logic [NSTG-1:0] reclTripSel,
  input wire logic [3:0] manualStartRst,
  input wire logic [2:0] extControlIn,
  input wire logic [8:0] extInSwgA,
  input wire logic [8:0] extInSwgB,
  input wire logic [8:0] extInSwgR,
  input wire logic resetBtn,
  input wire logic programBtn,
  input wire logic panelBankWr,
  input wire logic panelBankVal,
  input wire logic serialBankWr,
  input wire logic serialBankVal,
  input wire logic resetOutputsParam,
  input wire logic resetAllParam,
  input wire logic permFault,
  input wire logic [3:0] faultCode,
  output logic [NOUT-1:0] startOutputs,
  output logic [NOUT-1:0] tripOutputs,
  output logic recloseInitFirst,
  output logic recloseInitSecond,
  output logic recloseInitConfigurable,
  output logic bankSelectParam,
  output logic tripLed,
  output logic [3:0] operationCode,
  output logic intermittentLed,
  output logic supervisionRelay,
  output logic selfSupervisionAlarm,
  output logic [3:0] faultRedDigit,
  output logic [3:0] faultGreenCode,
  output logic clearRegisters
);
  import relay_out_pkg::*;

  // Stage decode is fixed to four stages and needs start output three
  if (NSTG != 4 || NOUT < 3) begin : gBadParams
    $error("Stage count must be 4 and outputs at least 3");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [8:0] pinsIn;
  logic [8:0] pinsSync;
  assign pinsIn = {extControlIn, resetBtn, programBtn, panelBankWr,
                   panelBankVal, serialBankWr, serialBankVal};
  pin_sync #(.WIDTH(9)) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .din(pinsIn),
    .dout(pinsSync)
  );
  logic [2:0] extIn;
  logic rstB, prgB, pBankWr, pBankV, sBankWr, sBankV;
  assign extIn = pinsSync[8:6];
  assign rstB = pinsSync[5];
  assign prgB = pinsSync[4];
  assign pBankWr = pinsSync[3];
  assign pBankV = pinsSync[2];
  assign sBankWr = pinsSync[1];
  assign sBankV = pinsSync[0];

  // ----------------------------------------
  // Reset source decode
  // ----------------------------------------
  logic clrInd, clrLatch, clrReg;
  logic [8:0] swg [3];
  assign swg[0] = extInSwgA;
  assign swg[1] = extInSwgB;
  assign swg[2] = extInSwgR;
  always_comb begin
    clrInd = rstB | prgB | resetOutputsParam | resetAllParam;
    clrLatch = prgB | resetOutputsParam | resetAllParam;
    clrReg = (rstB & prgB) | resetAllParam;
    for (int i = 0; i < 3; i++) begin
      if (extIn[i]) begin
        clrInd = clrInd | swg[i][`SGB_BIT_IND] | swg[i][`SGB_BIT_LATCH]
                 | swg[i][`SGB_BIT_REG];
        clrLatch = clrLatch | swg[i][`SGB_BIT_LATCH]
                   | swg[i][`SGB_BIT_REG];
        clrReg = clrReg | swg[i][`SGB_BIT_REG];
      end
    end
  end

  // ----------------------------------------
  // Output matrix and latching
  // ----------------------------------------
  logic [NOUT-1:0] startRaw, tripRaw, latch_r, latch_nxt;
  genvar o;
  generate
    for (o = 0; o < NOUT; o++) begin : gOut
      assign startRaw[o] = |(stageStart & startMatrix[o*NSTG +: NSTG]);
      assign tripRaw[o] = |(stageTrip & tripMatrix[o*NSTG +: NSTG]);
    end
  endgenerate
  always_comb begin
    // Clear only drops held state; a live trip still drives the output
    latch_nxt = (clrLatch ? '0 : latch_r) | (tripRaw & latchSel);
  end

  // ----------------------------------------
  // Indications
  // ----------------------------------------
  logic [NSTG-1:0] startInd_r, startInd_nxt, tripInd_r, tripInd_nxt;
  logic tripLed_nxt, interm_r, interm_nxt, bank_r, bank_nxt;
  code_t code_nxt;
  always_comb begin
    tripInd_nxt = (clrInd ? '0 : tripInd_r) | stageTrip;
    startInd_nxt = stageStart | ((clrInd ? '0 : startInd_r)
                   & manualStartRst & ~tripInd_nxt);
    tripLed_nxt = (clrInd ? 1'b0 : tripLed) | (|stageTrip);
    interm_nxt = (clrInd ? 1'b0 : interm_r)
                 | (intermittentOp & (stageTrip[3] | stageStart[3]));
    // Highest-ranked indication shown; codes are fixed
    if (tripInd_nxt[3]) begin
      code_nxt = `CODE_TR_TRIP;
    end else if (tripInd_nxt[2] | tripInd_nxt[1]) begin
      code_nxt = `CODE_HI_TRIP;
    end else if (tripInd_nxt[0]) begin
      code_nxt = `CODE_LO_TRIP;
    end else if (startInd_nxt[3]) begin
      code_nxt = `CODE_TR_START;
    end else if (startInd_nxt[2]) begin
      code_nxt = `CODE_U2_START;
    end else if (startInd_nxt[1]) begin
      code_nxt = `CODE_HI_START;
    end else if (startInd_nxt[0]) begin
      code_nxt = `CODE_LO_START;
    end else if (u1Start) begin
      code_nxt = `CODE_U1_START;
    end else begin
      code_nxt = `CODE_NONE;
    end
    bank_nxt = bank_r;
    if (sBankWr) begin
      bank_nxt = sBankV;
    end else if (pBankWr) begin
      bank_nxt = pBankV;
    end
    for (int i = 0; i < 3; i++) begin
      if (swg[i][0]) begin
        bank_nxt = bank_nxt | extIn[i];
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= '0;
      startInd_r <= '0;
      tripInd_r <= '0;
      tripLed <= 1'b0;
      interm_r <= 1'b0;
      bank_r <= 1'b0;
      startOutputs <= '0;
      tripOutputs <= '0;
      recloseInitFirst <= 1'b0;
      recloseInitSecond <= 1'b0;
      recloseInitConfigurable <= 1'b0;
      bankSelectParam <= 1'b0;
      operationCode <= `CODE_NONE;
      intermittentLed <= 1'b0;
      supervisionRelay <= 1'b0;
      selfSupervisionAlarm <= 1'b0;
      faultRedDigit <= 4'h0;
      faultGreenCode <= 4'h0;
      clearRegisters <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      startInd_r <= startInd_nxt;
      tripInd_r <= tripInd_nxt;
      tripLed <= tripLed_nxt;
      interm_r <= interm_nxt;
      bank_r <= bank_nxt;
      startOutputs <= startRaw;
      tripOutputs <= tripRaw | latch_nxt;
      recloseInitFirst <= startRaw[2];
      recloseInitSecond <= startRaw[0];
      recloseInitConfigurable <= |((stageStart & reclStartSel)
                                 | (stageTrip & reclTripSel));
      bankSelectParam <= bank_nxt;
      operationCode <= code_nxt;
      intermittentLed <= interm_nxt;
      supervisionRelay <= ~permFault;
      selfSupervisionAlarm <= permFault;
      // Fault code ignores all display reset sources
      faultRedDigit <= permFault ? `FAULT_DIGIT : 4'h0;
      faultGreenCode <= permFault ? faultCode : 4'h0;
      clearRegisters <= clrReg;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence tripSeen;
    |stageTrip;
  endsequence
  a_trip_led_hold: assert property (@(posedge clk) disable iff (!arst_n)
    tripSeen |=> tripLed) else $error("trip led not lit");
  a_led_stays: assert property (@(posedge clk) disable iff (!arst_n)
    tripLed && !clrInd |=> tripLed) else $error("trip led dropped");
  a_latch_hold: assert property (@(posedge clk) disable iff (!arst_n)
    tripOutputs[0] && latchSel[0] && !clrLatch |=> tripOutputs[0])
    else $error("latched trip lost");
  a_recl_first: assert property (@(posedge clk) disable iff (!arst_n)
    recloseInitFirst == startOutputs[2])
    else $error("reclose first mismatch");
  a_recl_second: assert property (@(posedge clk) disable iff (!arst_n)
    recloseInitSecond == startOutputs[0])
    else $error("reclose second mismatch");
  a_super_relay: assert property (@(posedge clk) disable iff (!arst_n)
    permFault |=> (!supervisionRelay && selfSupervisionAlarm))
    else $error("supervision relay wrong");
  a_fault_code: assert property (@(posedge clk) disable iff (!arst_n)
    selfSupervisionAlarm |-> faultRedDigit == `FAULT_DIGIT)
    else $error("fault digit wrong");
  a_tr_trip_code: assert property (@(posedge clk) disable iff (!arst_n)
    stageTrip[3] |=> operationCode == `CODE_TR_TRIP)
    else $error("transient trip code wrong");
  a_matrix_route: assert property (@(posedge clk) disable iff (!arst_n)
    (stageStart[1] && startMatrix[NSTG+1]) |=> startOutputs[1])
    else $error("start route missing");
endmodule
`default_nettype wire

//--- dv/serial_host_model.sv
// Serial host model issuing reset and bank parameters
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic clk,
  output var logic resetOutputsParam,
  output var logic resetAllParam,
  output var logic serialBankWr,
  output var logic serialBankVal
);
  initial begin
    resetOutputsParam = 1'b0;
    resetAllParam = 1'b0;
    serialBankWr = 1'b0;
    serialBankVal = 1'b0;
  end
  // One-cycle parameter write launched after a falling edge
  task automatic send(input int kind);
    @(negedge clk);
    resetOutputsParam = (kind == 1);
    resetAllParam = (kind == 2);
    serialBankWr = (kind == 3);
    serialBankVal = (kind == 3);
    @(negedge clk);
    resetOutputsParam = 1'b0;
    resetAllParam = 1'b0;
    serialBankWr = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the relay output matrix block
`timescale 1ns/1ps
`default_nettype none
`include "relay_out_params.svh"
module tb;
  import relay_out_pkg::*;
  logic clk, arst_n, u1Start, intermittentOp, resetBtn, programBtn;
  logic [3:0] stageStart, stageTrip, latchSel, reclStartSel, reclTripSel;
  logic [3:0] manualStartRst, faultCode, startOutputs, tripOutputs;
  logic [3:0] operationCode, faultRedDigit, faultGreenCode;
  logic [15:0] startMatrix, tripMatrix;
  logic panelBankWr, panelBankVal, serialBankWr, serialBankVal, permFault;
  logic resetOutputsParam, resetAllParam, clrSeen;
  logic [2:0] extControlIn;
  logic [8:0] extInSwgA, extInSwgB, extInSwgR;
  logic recloseInitFirst, recloseInitSecond, recloseInitConfigurable;
  logic bankSelectParam, tripLed, intermittentLed, supervisionRelay;
  logic selfSupervisionAlarm, clearRegisters;
  int n_errors, checks_done, cycles;
  code_t startCode [4] = '{`CODE_LO_START, `CODE_HI_START,
    `CODE_U2_START, `CODE_TR_START};

  relay_output_matrix_indication u_relay_output_matrix_indication (.clk,
    .arst_n, .stageStart, .stageTrip, .u1Start, .intermittentOp,
    .startMatrix, .tripMatrix, .latchSel, .reclStartSel, .reclTripSel,
    .manualStartRst, .extControlIn, .extInSwgA, .extInSwgB, .extInSwgR,
    .resetBtn, .programBtn, .panelBankWr, .panelBankVal, .serialBankWr,
    .serialBankVal, .resetOutputsParam, .resetAllParam, .permFault,
    .faultCode, .startOutputs, .tripOutputs, .recloseInitFirst,
    .recloseInitSecond, .recloseInitConfigurable, .bankSelectParam,
    .tripLed, .operationCode, .intermittentLed, .supervisionRelay,
    .selfSupervisionAlarm, .faultRedDigit, .faultGreenCode,
    .clearRegisters);
  serial_host_model u_serial_host_model (.clk, .resetOutputsParam,
    .resetAllParam, .serialBankWr, .serialBankVal);

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    if (clearRegisters === 1'b1) clrSeen = 1'b1;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Press buttons long enough to pass the synchroniser
  task automatic press(input logic r, input logic p);
    resetBtn = r;
    programBtn = p;
    cyc(6);
    resetBtn = 1'b0;
    programBtn = 1'b0;
    cyc(2);
  endtask
  task automatic latchTrip;
    stageTrip = 4'h8;
    cyc(2);
    stageTrip = 4'h0;
    clrSeen = 1'b0;
  endtask
  task automatic print_verdict;
    $display("n_errors %0d checks_done %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {arst_n, u1Start, intermittentOp, resetBtn, programBtn} = '0;
    {stageStart, stageTrip, reclStartSel, manualStartRst, faultCode} = '0;
    {panelBankWr, panelBankVal, permFault, extControlIn, clrSeen} = '0;
    {extInSwgA, extInSwgB, extInSwgR} = '0;
    startMatrix = 16'h0521;
    tripMatrix = 16'h0028;
    latchSel = 4'h1;
    reclTripSel = 4'h2;
    reclStartSel = 4'h4;
    cyc(4);
    arst_n = 1'b1;
    cyc(2);
    chk("supervisionRelay", 4'h1, {3'b0, supervisionRelay});
    stageTrip = 4'h8;
    intermittentOp = 1'b1;
    cyc(2);
    chk("tripOutputs", 4'h1, tripOutputs);
    chk("intermittentLed", 4'h1, {3'b0, intermittentLed});
    stageTrip = 4'h0;
    intermittentOp = 1'b0;
    cyc(2);
    chk("tripOutputs", 4'h1, tripOutputs);
    chk("tripLed", 4'h1, {3'b0, tripLed});
    chk("operationCode", `CODE_TR_TRIP, operationCode);
    press(1'b1, 1'b0);
    chk("tripLed", 4'h0, {3'b0, tripLed});
    chk("tripOutputs", 4'h1, tripOutputs);
    press(1'b0, 1'b1);
    chk("tripOutputs", 4'h0, tripOutputs);
    for (int i = 0; i < 4; i++) begin
      stageStart = 4'h1 << i;
      cyc(2);
      chk("operationCode", startCode[i], operationCode);
      stageStart = 4'h0;
      cyc(2);
      chk("operationCode", 4'h0, operationCode);
    end
    u1Start = 1'b1;
    cyc(2);
    chk("operationCode", `CODE_U1_START, operationCode);
    chk("intermittentLed", 4'h0, {3'b0, intermittentLed});
    u1Start = 1'b0;
    stageStart = 4'h4;
    cyc(2);
    chk("startOutputs", 4'h4, startOutputs);
    chk("recloseFirst", 4'h1, {3'b0, recloseInitFirst});
    chk("recloseSecond", 4'h0, {3'b0, recloseInitSecond});
    chk("recloseConf", 4'h1, {3'b0, recloseInitConfigurable});
    stageStart = 4'h1;
    cyc(2);
    chk("startOutputs", 4'h5, startOutputs);
    chk("recloseFirst", 4'h1, {3'b0, recloseInitFirst});
    chk("recloseSecond", 4'h1, {3'b0, recloseInitSecond});
    manualStartRst = 4'h1;
    stageStart = 4'h0;
    cyc(2);
    chk("operationCode", `CODE_LO_START, operationCode);
    {stageStart, stageTrip} = 8'h11;
    cyc(2);
    {stageStart, stageTrip} = 8'h00;
    cyc(2);
    chk("operationCode", `CODE_LO_TRIP, operationCode);
    chk("tripOutputs", 4'h0, tripOutputs);
    stageTrip = 4'h2;
    cyc(2);
    chk("recloseConf", 4'h1, {3'b0, recloseInitConfigurable});
    chk("operationCode", `CODE_HI_TRIP, operationCode);
    stageTrip = 4'h0;
    cyc(2);
    chk("recloseConf", 4'h0, {3'b0, recloseInitConfigurable});
    for (int i = 0; i < 3; i++) begin
      latchTrip();
      extInSwgA = (i == 0) ? 9'h020 : 9'h000;
      extInSwgB = (i == 1) ? 9'h040 : 9'h000;
      extInSwgR = (i == 2) ? 9'h080 : 9'h000;
      extControlIn = 3'b001 << i;
      cyc(6);
      extControlIn = 3'b000;
      cyc(2);
      chk("tripLed", 4'h0, {3'b0, tripLed});
      chk("tripOutputs", (i == 0) ? 4'h1 : 4'h0, tripOutputs);
      chk("clearRegisters", {3'b0, i == 2}, {3'b0, clrSeen});
    end
    {extInSwgA, extInSwgR} = '0;
    latchTrip();
    u_serial_host_model.send(1);
    cyc(2);
    chk("tripOutputs", 4'h0, tripOutputs);
    chk("clearRegisters", 4'h0, {3'b0, clrSeen});
    latchTrip();
    u_serial_host_model.send(2);
    cyc(2);
    chk("clearRegisters", 4'h1, {3'b0, clrSeen});
    clrSeen = 1'b0;
    press(1'b1, 1'b1);
    chk("clearRegisters", 4'h1, {3'b0, clrSeen});
    u_serial_host_model.send(3);
    cyc(2);
    chk("bankSelect", 4'h1, {3'b0, bankSelectParam});
    panelBankWr = 1'b1;
    cyc(6);
    panelBankWr = 1'b0;
    cyc(2);
    chk("bankSelect", 4'h0, {3'b0, bankSelectParam});
    extInSwgB = 9'h001;
    extControlIn = 3'b010;
    cyc(6);
    chk("bankSelect", 4'h1, {3'b0, bankSelectParam});
    extControlIn = 3'b000;
    faultCode = 4'hA;
    permFault = 1'b1;
    cyc(2);
    chk("supervisionRelay", 4'h0, {3'b0, supervisionRelay});
    chk("alarm", 4'h1, {3'b0, selfSupervisionAlarm});
    press(1'b1, 1'b1);
    chk("faultRedDigit", `FAULT_DIGIT, faultRedDigit);
    chk("faultGreenCode", 4'hA, faultGreenCode);
    print_verdict();
  end
endmodule
`default_nettype wire
